// file: logic/ppdec_pkg.sv
// Package for the parallel port register decode block.
// Holds register offsets, mode codes, field positions and reset values.
// Assumes the AXI4-Lite slave maps each register to one aligned word.
package ppdec_pkg;
	// Printed offsets are register indexes; byte address is index times 4
	localparam logic [10:0] IDX_DATA = 11'h000;
	localparam logic [10:0] IDX_STATUS = 11'h001;
	localparam logic [10:0] IDX_CONTROL = 11'h002;
	localparam logic [10:0] IDX_EPP_ADDR = 11'h003;
	localparam logic [10:0] IDX_EPP_EPP_DATA_PORT_0 = 11'h004;
	localparam logic [10:0] IDX_EPP_EPP_DATA_PORT_3 = 11'h007;
	localparam logic [10:0] IDX_HIGH_FIFO = 11'h400;
	localparam logic [10:0] IDX_CONFIG_B = 11'h401;
	localparam logic [10:0] IDX_EXT_CTRL = 11'h402;
	localparam logic [10:0] IDX_IND_INDEX = 11'h403;
	localparam logic [10:0] IDX_IND_DATA = 11'h404;
	localparam logic [10:0] IDX_AUX_STATUS = 11'h405;
	// Byte address width: index plus two byte bits
	localparam int ADDR_W = 13;
	localparam int IDX_LSB = 2;
	// Transfer modes in extended control bits 7:5
	localparam logic [2:0] MODE_COMPAT = 3'h0;
	localparam logic [2:0] MODE_BIDIR = 3'h1;
	localparam logic [2:0] MODE_FIFO = 3'h2;
	localparam logic [2:0] MODE_ECP = 3'h3;
	localparam logic [2:0] MODE_EPP = 3'h4;
	localparam logic [2:0] MODE_TEST = 3'h6;
	localparam logic [2:0] MODE_CONFIG = 3'h7;
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 5;
	// Second-level indexes
	localparam logic [2:0] SL_CTRL_A = 3'h0;
	localparam logic [2:0] SL_CTRL_B = 3'h2;
	localparam logic [2:0] SL_CTRL_C = 3'h4;
	localparam logic [2:0] SL_PORT_CFG = 3'h5;
	localparam int SL_IDX_W = 3;
	// Config A bit 3 mirrors port config bit 7
	localparam int CFGA_BIT = 3;
	localparam int PCFG_BIT = 7;
	// Extended control bits 7:2 that software may write; bits 1:0 are not written
	localparam logic [7:0] ECR_WR_MASK = 8'hFC;
	localparam int ECR_FULL_BIT = 1;
	localparam int ECR_EMPTY_BIT = 0;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] RST_ECR = 8'h00;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Byte lane carrying the 8-bit register value
	localparam int LANE0 = 0;
endpackage

// file: logic/ppdec_byte_reg.sv
// One 8-bit software-writable register with synchronous reset.
// Assumes the caller decodes the write strobe.
`timescale 1ns/1ps
`default_nettype none
module ppdec_byte_reg (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Write port
	input wire logic wr_in,
	input wire logic [7:0] data_in,
	// Stored value
	output logic [7:0] value_out
);
	// Register holding the written byte
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			value_out <= ppdec_pkg::RST_BYTE;
		end else if (wr_in) begin
			value_out <= data_in;
		end
	end
endmodule
`default_nettype wire

// file: logic/ppdec_sl_bank.sv
// Second-level register bank reached through the indirect index/data pair.
// Assumes the top module selects an index and strobes writes.
`timescale 1ns/1ps
`default_nettype none
module ppdec_sl_bank (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Indirect access
	input wire logic [2:0] index_in,
	input wire logic wr_in,
	input wire logic [7:0] data_in,
	// Read back and port config
	output logic [7:0] rdata_out,
	output logic [7:0] port_cfg_out
);
	logic [7:0] ctrl_a; // Control register A
	logic [7:0] ctrl_b; // Control register B
	logic [7:0] ctrl_c; // Control register C
	logic [3:0] hit; // One-hot write select

	always_comb begin
		hit = 4'h0;
		case (index_in)
			ppdec_pkg::SL_CTRL_A: hit[0] = wr_in;
			ppdec_pkg::SL_CTRL_B: hit[1] = wr_in;
			ppdec_pkg::SL_CTRL_C: hit[2] = wr_in;
			ppdec_pkg::SL_PORT_CFG: hit[3] = wr_in;
			default: hit = 4'h0;
		endcase
	end

	ppdec_byte_reg u_a (.clk_in(clk_in), .rst_in(rst_in), .wr_in(hit[0]),
		.data_in(data_in), .value_out(ctrl_a));
	ppdec_byte_reg u_b (.clk_in(clk_in), .rst_in(rst_in), .wr_in(hit[1]),
		.data_in(data_in), .value_out(ctrl_b));
	ppdec_byte_reg u_c (.clk_in(clk_in), .rst_in(rst_in), .wr_in(hit[2]),
		.data_in(data_in), .value_out(ctrl_c));
	ppdec_byte_reg u_p (.clk_in(clk_in), .rst_in(rst_in), .wr_in(hit[3]),
		.data_in(data_in), .value_out(port_cfg_out));

	// Read mux; unused indexes read as zero
	always_comb begin
		case (index_in)
			ppdec_pkg::SL_CTRL_A: rdata_out = ctrl_a;
			ppdec_pkg::SL_CTRL_B: rdata_out = ctrl_b;
			ppdec_pkg::SL_CTRL_C: rdata_out = ctrl_c;
			ppdec_pkg::SL_PORT_CFG: rdata_out = port_cfg_out;
			default: rdata_out = ppdec_pkg::RST_BYTE;
		endcase
	end
endmodule
`default_nettype wire

// file: logic/ppdec_top.sv
// Parallel port register decode with an AXI4-Lite slave.
// Assumes a single AXI master; the cable side is plain ports.
`timescale 1ns/1ps
`default_nettype none
module ppdec_top (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [12:0] s_axi_awaddr_in,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	// AXI4-Lite write response
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	output logic [1:0] s_axi_bresp_out,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	input wire logic [12:0] s_axi_araddr_in,
	// AXI4-Lite read data
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	// Port placement strap and peripheral status
	input wire logic base_aligned_in,
	input wire logic [7:0] port_status_in,
	input wire logic [7:0] config_b_in,
	input wire logic fifo_full_in,
	input wire logic fifo_empty_in,
	input wire logic [7:0] fifo_rdata_in,
	input wire logic [7:0] aux_status_in,
	// Data toward the cable side
	output logic [7:0] data_latch_out,
	output logic [7:0] port_control_out,
	output logic [7:0] epp_address_out,
	output logic [2:0] mode_out,
	// Writes steered to the FIFOs and EPP data ports, and EPP data reads
	output logic fifo_wr_out,
	output logic fifo_is_addr_out,
	output logic [7:0] fifo_wdata_out,
	output logic epp_data_wr_out,
	output logic epp_data_rd_out,
	output logic [1:0] epp_port_out,
	output logic [7:0] epp_wdata_out,
	input wire logic [7:0] epp_rdata_in,
	// Second-level port configuration
	output logic [7:0] port_cfg_out
);
	////////////////////////////////////////////////////////////////////
	// Write channel capture: address and data taken in either order
	logic aw_held_q; // Address taken
	logic w_held_q; // Data taken
	logic [10:0] aw_idx_q; // Write register index
	logic [7:0] w_byte_q; // Write byte lane 0
	logic w_lane_q; // Lane 0 enabled
	logic wr_go; // Both halves present, response free
	logic [7:0] ecr_q; // Extended control
	logic [7:0] ind_idx_q; // Indirect index
	logic [2:0] mode; // Current mode
	logic epp_ok; // EPP decode allowed
	logic sl_ok; // Indirect decode allowed
	logic wr_hit; // Write decoded to a register
	logic wr_data_latch;
	logic wr_control;
	logic wr_epp_addr;
	logic wr_fifo;
	logic wr_ecr;
	logic wr_idx;
	logic wr_ind;
	logic wr_epp_data;
	logic [7:0] sl_rdata;
	logic [7:0] sl_cfg;

	// Ready on alternate cycles while the half is not yet held
	assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid_out;
	assign mode = ecr_q[ppdec_pkg::MODE_HI:ppdec_pkg::MODE_LO];
	assign epp_ok = base_aligned_in && (mode == ppdec_pkg::MODE_EPP);
	assign sl_ok = base_aligned_in;

	// Address half of a write
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			aw_held_q <= 1'b0;
			aw_idx_q <= ppdec_pkg::IDX_DATA;
			s_axi_awready_out <= 1'b0;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_held_q <= 1'b1;
				aw_idx_q <= s_axi_awaddr_in[ppdec_pkg::ADDR_W-1:ppdec_pkg::IDX_LSB];
			end else if (wr_go) begin
				aw_held_q <= 1'b0;
			end
			s_axi_awready_out <= !aw_held_q && !s_axi_awready_out;
		end
	end

	// Data half of a write
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			w_held_q <= 1'b0;
			w_byte_q <= ppdec_pkg::RST_BYTE;
			w_lane_q <= 1'b0;
			s_axi_wready_out <= 1'b0;
		end else begin
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_held_q <= 1'b1;
				w_byte_q <= s_axi_wdata_in[7:0];
				w_lane_q <= s_axi_wstrb_in[ppdec_pkg::LANE0];
			end else if (wr_go) begin
				w_held_q <= 1'b0;
			end
			s_axi_wready_out <= !w_held_q && !s_axi_wready_out;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Write decode by index and mode
	always_comb begin
		wr_data_latch = 1'b0;
		wr_control = 1'b0;
		wr_epp_addr = 1'b0;
		wr_fifo = 1'b0;
		wr_ecr = 1'b0;
		wr_idx = 1'b0;
		wr_ind = 1'b0;
		wr_epp_data = 1'b0;
		wr_hit = 1'b1;
		case (aw_idx_q)
			ppdec_pkg::IDX_DATA: begin
				if (mode == ppdec_pkg::MODE_COMPAT || mode == ppdec_pkg::MODE_BIDIR) begin
					wr_data_latch = 1'b1;
				end else if (mode == ppdec_pkg::MODE_ECP) begin
					wr_fifo = 1'b1;
				end else begin
					wr_hit = 1'b0;
				end
			end
			ppdec_pkg::IDX_CONTROL: wr_control = 1'b1;
			ppdec_pkg::IDX_EPP_ADDR: begin
				wr_epp_addr = epp_ok;
				wr_hit = epp_ok;
			end
			ppdec_pkg::IDX_HIGH_FIFO: begin
				wr_fifo = (mode == ppdec_pkg::MODE_FIFO) ||
					(mode == ppdec_pkg::MODE_ECP) || (mode == ppdec_pkg::MODE_TEST);
				wr_hit = wr_fifo;
			end
			ppdec_pkg::IDX_EXT_CTRL: wr_ecr = 1'b1;
			ppdec_pkg::IDX_IND_INDEX: begin
				wr_idx = sl_ok;
				wr_hit = sl_ok;
			end
			ppdec_pkg::IDX_IND_DATA: begin
				wr_ind = sl_ok;
				wr_hit = sl_ok;
			end
			ppdec_pkg::IDX_AUX_STATUS: wr_hit = 1'b1;
			default: begin
				if (aw_idx_q >= ppdec_pkg::IDX_EPP_EPP_DATA_PORT_0 &&
					aw_idx_q <= ppdec_pkg::IDX_EPP_EPP_DATA_PORT_3) begin
					wr_epp_data = epp_ok;
					wr_hit = epp_ok;
				end else begin
					wr_hit = 1'b0;
				end
			end
		endcase
	end

	// Data latch, control and EPP address via byte registers
	ppdec_byte_reg u_latch (.clk_in(clk_in), .rst_in(rst_in),
		.wr_in(wr_go && w_lane_q && wr_data_latch), .data_in(w_byte_q),
		.value_out(data_latch_out));
	ppdec_byte_reg u_ctrl (.clk_in(clk_in), .rst_in(rst_in),
		.wr_in(wr_go && w_lane_q && wr_control), .data_in(w_byte_q),
		.value_out(port_control_out));
	ppdec_byte_reg u_eppa (.clk_in(clk_in), .rst_in(rst_in),
		.wr_in(wr_go && w_lane_q && wr_epp_addr), .data_in(w_byte_q),
		.value_out(epp_address_out));

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ecr_q <= ppdec_pkg::RST_ECR;
		end else if (wr_go && w_lane_q && wr_ecr) begin
			ecr_q <= w_byte_q & ppdec_pkg::ECR_WR_MASK;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ind_idx_q <= ppdec_pkg::RST_BYTE;
		end else if (wr_go && w_lane_q && wr_idx) begin
			ind_idx_q <= w_byte_q;
		end
	end

	ppdec_sl_bank u_sl (.clk_in(clk_in), .rst_in(rst_in),
		.index_in(ind_idx_q[ppdec_pkg::SL_IDX_W-1:0]),
		.wr_in(wr_go && w_lane_q && wr_ind), .data_in(w_byte_q),
		.rdata_out(sl_rdata), .port_cfg_out(sl_cfg));

	// Strobes toward FIFOs and EPP ports, plus mirrored state
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fifo_wr_out <= 1'b0;
			fifo_is_addr_out <= 1'b0;
			fifo_wdata_out <= ppdec_pkg::RST_BYTE;
			epp_data_wr_out <= 1'b0;
			epp_wdata_out <= ppdec_pkg::RST_BYTE;
			mode_out <= ppdec_pkg::MODE_COMPAT;
			port_cfg_out <= ppdec_pkg::RST_BYTE;
		end else begin
			fifo_wr_out <= wr_go && w_lane_q && wr_fifo;
			fifo_is_addr_out <= (aw_idx_q == ppdec_pkg::IDX_DATA);
			fifo_wdata_out <= w_byte_q;
			epp_data_wr_out <= wr_go && w_lane_q && wr_epp_data;
			epp_wdata_out <= w_byte_q;
			mode_out <= mode;
			port_cfg_out <= sl_cfg;
		end
	end

	// Write response; unmapped gives SLVERR
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= ppdec_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid_out <= 1'b1;
			s_axi_bresp_out <= wr_hit ? ppdec_pkg::RESP_OKAY : ppdec_pkg::RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			s_axi_bvalid_out <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Read path: one cycle after address is taken
	logic [10:0] ar_idx;
	logic [7:0] rd_byte;
	logic rd_hit;
	logic rd_epp;
	logic [7:0] ecr_view;

	assign ar_idx = s_axi_araddr_in[ppdec_pkg::ADDR_W-1:ppdec_pkg::IDX_LSB];
	// Live FIFO flags replace stored low bits
	always_comb begin
		ecr_view = ecr_q;
		ecr_view[ppdec_pkg::ECR_FULL_BIT] = fifo_full_in;
		ecr_view[ppdec_pkg::ECR_EMPTY_BIT] = fifo_empty_in;
	end

	// Read mux by index and mode
	always_comb begin
		rd_byte = ppdec_pkg::RST_BYTE;
		rd_hit = 1'b1;
		rd_epp = 1'b0;
		case (ar_idx)
			// data latch readable in modes 000/001
			ppdec_pkg::IDX_DATA: begin
				rd_hit = (mode == ppdec_pkg::MODE_COMPAT) || (mode == ppdec_pkg::MODE_BIDIR);
				rd_byte = data_latch_out;
			end
			ppdec_pkg::IDX_STATUS: rd_byte = port_status_in;
			ppdec_pkg::IDX_CONTROL: rd_byte = port_control_out;
			ppdec_pkg::IDX_EPP_ADDR: begin
				rd_hit = epp_ok;
				rd_byte = epp_address_out;
			end
			ppdec_pkg::IDX_HIGH_FIFO: begin
				if (mode == ppdec_pkg::MODE_ECP || mode == ppdec_pkg::MODE_TEST) begin
					rd_byte = fifo_rdata_in;
				end else if (mode == ppdec_pkg::MODE_CONFIG) begin
					rd_byte[ppdec_pkg::CFGA_BIT] = sl_cfg[ppdec_pkg::PCFG_BIT];
				end else begin
					rd_hit = 1'b0;
				end
			end
			ppdec_pkg::IDX_CONFIG_B: begin
				rd_hit = (mode == ppdec_pkg::MODE_CONFIG);
				rd_byte = config_b_in;
			end
			ppdec_pkg::IDX_EXT_CTRL: rd_byte = ecr_view;
			ppdec_pkg::IDX_IND_INDEX: begin
				rd_hit = sl_ok;
				rd_byte = ind_idx_q;
			end
			ppdec_pkg::IDX_IND_DATA: begin
				rd_hit = sl_ok;
				rd_byte = sl_rdata;
			end
			ppdec_pkg::IDX_AUX_STATUS: rd_byte = aux_status_in;
			default: begin
				if (ar_idx >= ppdec_pkg::IDX_EPP_EPP_DATA_PORT_0 && ar_idx <= ppdec_pkg::IDX_EPP_EPP_DATA_PORT_3) begin
					rd_hit = epp_ok;
					rd_epp = epp_ok;
					rd_byte = epp_rdata_in;
				end else begin
					rd_hit = 1'b0;
				end
			end
		endcase
	end

	// Read handshake and data; also EPP port select
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h00000000;
			s_axi_rresp_out <= ppdec_pkg::RESP_OKAY;
			epp_data_rd_out <= 1'b0;
			epp_port_out <= 2'h0;
		end else begin
			epp_data_rd_out <= 1'b0;
			s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out &&
				s_axi_arvalid_in;
			if (s_axi_arvalid_in && s_axi_arready_out) begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out <= {24'h000000, rd_hit ? rd_byte : ppdec_pkg::RST_BYTE};
				s_axi_rresp_out <= rd_hit ? ppdec_pkg::RESP_OKAY : ppdec_pkg::RESP_SLVERR;
				epp_data_rd_out <= rd_epp;
			end else if (s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
			if (wr_go && wr_epp_data) begin
				epp_port_out <= aw_idx_q[1:0];
			end else if (s_axi_arvalid_in && s_axi_arready_out && rd_epp) begin
				epp_port_out <= ar_idx[1:0];
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/ppdec_asserts.sv
// Checker for the parallel port register decode, watching top ports.
// Assumes one clock, a synchronous reset and one read at a time.
`timescale 1ns/1ps
`default_nettype none
module ppdec_asserts (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Read channel
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic [12:0] s_axi_araddr_in,
	input wire logic s_axi_rvalid_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0] s_axi_rresp_out,
	// Decode side
	input wire logic base_aligned_in,
	input wire logic [2:0] mode_out,
	input wire logic fifo_wr_out,
	input wire logic fifo_is_addr_out,
	input wire logic epp_data_wr_out,
	input wire logic epp_data_rd_out,
	input wire logic [7:0] port_cfg_out
);
	// Index and strap seen when a read was taken
	logic [10:0] ridx_q;
	logic al_q;
	////////////////////////////////////////////////////////////////////
	// Capture read context, so the answer can be judged by its cause
	always_ff @(posedge clk_in) begin
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			ridx_q <= s_axi_araddr_in[12:2];
			al_q <= base_aligned_in;
		end
	end
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Read request accepted
	sequence rd_taken;
		s_axi_arvalid_in && s_axi_arready_out;
	endsequence
	// Read answer appears
	sequence rd_done;
		$rose(s_axi_rvalid_out);
	endsequence
	////////////////////////////////////////////////////////////////////
	chk_rd_latency: assert property (rd_taken |=> rd_done)
		else $error("read answer not one cycle after request");
	chk_common_ok: assert property (rd_done ##0 (ridx_q inside
		{11'h001, 11'h002, 11'h402, 11'h405}) |-> s_axi_rresp_out == 2'h0)
		else $error("common register refused");
	chk_unaligned_err: assert property (rd_done ##0 (!al_q &&
		(ridx_q inside {[11'h003:11'h007], 11'h403, 11'h404}))
		|-> s_axi_rresp_out == 2'h2)
		else $error("unaligned access answered");
	chk_cfga_bit: assert property (rd_done ##0 (ridx_q == 11'h400 &&
		mode_out == 3'h7) |-> s_axi_rdata_out ==
		{28'h0, port_cfg_out[7], 3'h0})
		else $error("config A bit wrong");
	chk_cfgb_mode: assert property (rd_done ##0 (ridx_q == 11'h401 &&
		mode_out != 3'h7) |-> s_axi_rresp_out == 2'h2)
		else $error("config B outside config mode");
	chk_fifo_mode: assert property (fifo_wr_out |->
		mode_out inside {3'h2, 3'h3, 3'h6})
		else $error("fifo write in wrong mode");
	chk_ecp_address_fifo_mode: assert property (fifo_wr_out && fifo_is_addr_out
		|-> mode_out == 3'h3)
		else $error("address fifo write outside ECP mode");
	chk_epp_gate: assert property ((epp_data_wr_out || epp_data_rd_out)
		|-> mode_out == 3'h4 && base_aligned_in)
		else $error("EPP strobe outside EPP mode");
	chk_epp_pulse: assert property (epp_data_wr_out || epp_data_rd_out
		|=> !epp_data_wr_out && !epp_data_rd_out)
		else $error("EPP strobe longer than one cycle");
endmodule
bind ppdec_top ppdec_asserts ppdec_asserts_inst (
	.clk_in(clk_in),
	.rst_in(rst_in),
	.s_axi_arvalid_in(s_axi_arvalid_in),
	.s_axi_arready_out(s_axi_arready_out),
	.s_axi_araddr_in(s_axi_araddr_in),
	.s_axi_rvalid_out(s_axi_rvalid_out),
	.s_axi_rdata_out(s_axi_rdata_out),
	.s_axi_rresp_out(s_axi_rresp_out),
	.base_aligned_in(base_aligned_in),
	.mode_out(mode_out),
	.fifo_wr_out(fifo_wr_out),
	.fifo_is_addr_out(fifo_is_addr_out),
	.epp_data_wr_out(epp_data_wr_out),
	.epp_data_rd_out(epp_data_rd_out),
	.port_cfg_out(port_cfg_out)
);
`default_nettype wire

// file: tb/ppdec_cable_model.sv
// Peripheral on the cable: fixed status and read bytes.
// Assumes the bench knows the parameter values it hands in.
`timescale 1ns/1ps
`default_nettype none
module ppdec_cable_model #(
	parameter logic [7:0] STATUS = 8'h78,
	parameter logic [7:0] CFGB = 8'h41,
	parameter logic [7:0] FIFO_RD = 8'h3A,
	parameter logic [7:0] AUX = 8'h80,
	parameter logic [7:0] EPP_RD = 8'h5C
) (
	// Lines seen by the port
	output logic [7:0] port_status_out,
	output logic [7:0] config_b_out,
	output logic fifo_full_out,
	output logic fifo_empty_out,
	output logic [7:0] fifo_rdata_out,
	output logic [7:0] aux_status_out,
	output logic [7:0] epp_rdata_out
);
	// Held steady, so a read taken at any cycle has one answer
	assign port_status_out = STATUS;
	assign config_b_out = CFGB;
	// Full and empty differ, so swapped flag bits show
	assign fifo_full_out = 1'b1;
	assign fifo_empty_out = 1'b0;
	assign fifo_rdata_out = FIFO_RD;
	assign aux_status_out = AUX;
	assign epp_rdata_out = EPP_RD;
endmodule
`default_nettype wire

// file: tb/tb_parallel_port_register_decode.sv
// Bench for the parallel port register decode over AXI4-Lite.
// Assumes the cable model holds its lines at fixed values.
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_port_register_decode;
	localparam logic [1:0] OK = ppdec_pkg::RESP_OKAY;
	localparam logic [1:0] ER = ppdec_pkg::RESP_SLVERR;
	// Clock, reset and bus drives
	logic clk_in, rst_in, aw_v, w_v, b_r, ar_v, r_r, al;
	logic [12:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	// Port outputs and cable lines
	logic [7:0] latch, ctrl, eaddr, pcfg, st, cb, frd, aux, erd;
	// Steered write bytes and the last ones caught on a strobe
	logic [7:0] fwd, ewd, fd, ed;
	logic [1:0] eport, ep;
	// Write byte strobes, lowered once to show a lane-less write is dropped
	logic [3:0] ws;
	logic [2:0] mode;
	logic fwr, fadr, ewr, erdp, full, empty;
	int failures = 0, num_checks = 0, nf = 0, nw = 0, nr = 0, na = 0, m;
	////////////////////////////////////////////////////////////////////
	ppdec_top ppdec_top_inst (.clk_in(clk_in), .rst_in(rst_in),
		.s_axi_awvalid_in(aw_v), .s_axi_awready_out(awready),
		.s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(w_v),
		.s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(ws), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(b_r), .s_axi_bresp_out(bresp),
		.s_axi_arvalid_in(ar_v), .s_axi_arready_out(arready),
		.s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(r_r), .s_axi_rdata_out(rdata),
		.s_axi_rresp_out(rresp), .base_aligned_in(al),
		.port_status_in(st), .config_b_in(cb), .fifo_full_in(full),
		.fifo_empty_in(empty), .fifo_rdata_in(frd),
		.aux_status_in(aux), .data_latch_out(latch),
		.port_control_out(ctrl), .epp_address_out(eaddr),
		.mode_out(mode), .fifo_wr_out(fwr), .fifo_is_addr_out(fadr),
		.fifo_wdata_out(fwd), .epp_data_wr_out(ewr),
		.epp_data_rd_out(erdp), .epp_port_out(eport),
		.epp_wdata_out(ewd),
		.epp_rdata_in(erd), .port_cfg_out(pcfg));
	ppdec_cable_model ppdec_cable_model_inst (.port_status_out(st),
		.config_b_out(cb), .fifo_full_out(full),
		.fifo_empty_out(empty), .fifo_rdata_out(frd),
		.aux_status_out(aux), .epp_rdata_out(erd));
	////////////////////////////////////////////////////////////////////
	// Free-running 50 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	// Count strobes toward the FIFOs and EPP ports
	always @(posedge clk_in) begin
		if (fwr) nf <= nf + 1;
		if (fwr) fd <= fwd;
		if (fwr && fadr) na <= na + 1;
		if (ewr) nw <= nw + 1;
		if (ewr) ep <= eport;
		if (ewr) ed <= ewd;
		if (erdp) nr <= nr + 1;
	end
	// Compare one value, log a mismatch
	task automatic chk(input string nm, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Print the verdict and stop
	task automatic give_verdict;
		if (failures == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Write; address and data offered together, each dropped when taken
	task automatic wr(input logic [10:0] i, input logic [7:0] d,
		input logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk_in);
		awaddr <= {i, 2'h0};
		wdata <= {24'h0, d};
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (awready) aw_v <= 1'b0;
			if (wready) w_v <= 1'b0;
		end while (!bvalid && n < 50);
		b_r <= 1'b0;
		if (n >= 50) begin
			failures++;
			give_verdict();
		end
		chk("bresp", {30'h0, bresp}, {30'h0, r});
	endtask
	// Read; response code and data judged together
	task automatic rd(input logic [10:0] i, input logic [7:0] e,
		input logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk_in);
		araddr <= {i, 2'h0};
		ar_v <= 1'b1;
		r_r <= 1'b1;
		do begin
			@(posedge clk_in);
			n++;
			if (arready) ar_v <= 1'b0;
		end while (!rvalid && n < 50);
		r_r <= 1'b0;
		if (n >= 50) begin
			failures++;
			give_verdict();
		end
		chk("rresp", {30'h0, rresp}, {30'h0, r});
		chk("rdata", rdata, {24'h0, e});
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		{rst_in, al, aw_v, w_v, b_r, ar_v, r_r} = 7'h60;
		{awaddr, araddr, wdata} = '0;
		ws = 4'hF;
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		// Every mode: shared offsets and mode-bound registers
		for (m = 0; m < 8; m++) begin
			wr(ppdec_pkg::IDX_EXT_CTRL, {m[2:0], 5'h00}, OK);
			rd(ppdec_pkg::IDX_EXT_CTRL, {m[2:0], 5'h02}, OK);
			chk("mode", {29'h0, mode}, m);
			rd(ppdec_pkg::IDX_STATUS, 8'h78, OK);
			rd(ppdec_pkg::IDX_AUX_STATUS, 8'h80, OK);
			wr(ppdec_pkg::IDX_CONTROL, {m[2:0], 5'h0A}, OK);
			rd(ppdec_pkg::IDX_CONTROL, {m[2:0], 5'h0A}, OK);
			rd(ppdec_pkg::IDX_DATA, 8'h00, m < 2 ? OK : ER);
			rd(ppdec_pkg::IDX_HIGH_FIFO, (m == 3 || m == 6) ? 8'h3A : 8'h00,
				(m == 3 || m > 5) ? OK : ER);
			rd(ppdec_pkg::IDX_CONFIG_B, m == 7 ? 8'h41 : 8'h00,
				m == 7 ? OK : ER);
			rd(ppdec_pkg::IDX_EPP_ADDR, 8'h00, m == 4 ? OK : ER);
		end
		// A write with no byte lane enabled leaves the register alone
		ws <= 4'h0;
		wr(ppdec_pkg::IDX_CONTROL, 8'h15, OK);
		ws <= 4'hF;
		rd(ppdec_pkg::IDX_CONTROL, 8'hEA, OK);
		chk("control", {24'h0, ctrl}, 32'hEA);
		// Indirect bank, holes at 1 and 3 read back zero
		for (m = 0; m < 6; m++) begin
			wr(ppdec_pkg::IDX_IND_INDEX, m[7:0], OK);
			wr(ppdec_pkg::IDX_IND_DATA, 8'h80 | m[7:0], OK);
		end
		for (m = 0; m < 6; m++) begin
			wr(ppdec_pkg::IDX_IND_INDEX, m[7:0], OK);
			rd(ppdec_pkg::IDX_IND_INDEX, m[7:0], OK);
			rd(ppdec_pkg::IDX_IND_DATA, (m == 1 || m == 3) ? 8'h00 :
				8'h80 | m[7:0], OK);
		end
		chk("port_cfg", {24'h0, pcfg}, 32'h85);
		rd(ppdec_pkg::IDX_HIGH_FIFO, 8'h08, OK);
		// Data latch, then writes steered per mode
		wr(ppdec_pkg::IDX_EXT_CTRL, 8'h00, OK);
		wr(ppdec_pkg::IDX_DATA, 8'hA5, OK);
		rd(ppdec_pkg::IDX_DATA, 8'hA5, OK);
		chk("latch", {24'h0, latch}, 32'hA5);
		wr(ppdec_pkg::IDX_HIGH_FIFO, 8'h55, ER);
		wr(ppdec_pkg::IDX_EXT_CTRL, 8'h60, OK);
		wr(ppdec_pkg::IDX_DATA, 8'h11, OK);
		wr(ppdec_pkg::IDX_HIGH_FIFO, 8'h22, OK);
		wr(ppdec_pkg::IDX_EXT_CTRL, 8'h40, OK);
		wr(ppdec_pkg::IDX_HIGH_FIFO, 8'h33, OK);
		wr(ppdec_pkg::IDX_EXT_CTRL, 8'hC0, OK);
		wr(ppdec_pkg::IDX_HIGH_FIFO, 8'h44, OK);
		// EPP address and the four data ports
		wr(ppdec_pkg::IDX_EXT_CTRL, 8'h80, OK);
		wr(ppdec_pkg::IDX_EPP_ADDR, 8'h5A, OK);
		rd(ppdec_pkg::IDX_EPP_ADDR, 8'h5A, OK);
		chk("epp_addr", {24'h0, eaddr}, 32'h5A);
		for (m = 0; m < 4; m++) begin
			wr(ppdec_pkg::IDX_EPP_EPP_DATA_PORT_0 + 11'(m), m[7:0], OK);
			rd(ppdec_pkg::IDX_EPP_EPP_DATA_PORT_0 + 11'(m), 8'h5C, OK);
			chk("epp_port", {30'h0, ep}, m);
			chk("epp_wdata", {24'h0, ed}, m);
		end
		// Misaligned base hides EPP and indirect registers
		al <= 1'b0;
		rd(ppdec_pkg::IDX_EPP_ADDR, 8'h00, ER);
		wr(ppdec_pkg::IDX_EPP_EPP_DATA_PORT_3, 8'h01, ER);
		rd(ppdec_pkg::IDX_IND_INDEX, 8'h00, ER);
		rd(ppdec_pkg::IDX_IND_DATA, 8'h00, ER);
		rd(11'h008, 8'h00, ER);
		rd(11'h406, 8'h00, ER);
		chk("fifo_wdata", {24'h0, fd}, 32'h44);
		chk("fifo_addr", na, 1);
		chk("fifo_wr", nf, 4);
		chk("epp_wr", nw, 4);
		chk("epp_rd", nr, 4);
		give_verdict();
	end
endmodule
`default_nettype wire
